// [verilog/trace_store_pkg.sv]
package trace_store_pkg;

   // captured bus state width
   localparam int STATE_W = 64;
   // count field width
   localparam int COUNT_W = 32;
   // trace depth with a count field
   localparam logic [10:0] DEPTH_COUNTED = 11'h200;
   // trace depth with counting off
   localparam logic [10:0] DEPTH_NO_COUNT = 11'h400;
   // address width of the full memory
   localparam int ADDR_W = 10;
   // number of pre-store slots
   localparam int PRE_SLOTS = 2;
   // pre-store slot count width
   localparam int PRE_CNT_W = 2;

   // register byte offsets
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] IRQ_OFS    = 8'h08;
   localparam logic [7:0] MASK_OFS   = 8'h0C;
   localparam logic [7:0] FILL_OFS   = 8'h10;
   localparam logic [7:0] RADDR_OFS  = 8'h14;
   localparam logic [7:0] RSTAT_LO   = 8'h18;
   localparam logic [7:0] RSTAT_HI   = 8'h1C;
   localparam logic [7:0] RCOUNT_OFS = 8'h20;
   localparam logic [7:0] RTAG_OFS   = 8'h24;

   // control field positions
   localparam int CTRL_START   = 0;
   localparam int CTRL_HALT    = 1;
   localparam int CTRL_PRE_EN  = 2;
   localparam int CTRL_MODE_LO = 3;
   localparam int CTRL_ON_HALT = 5;
   // control reset value: pre-store off, time counting
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // interrupt bit positions
   localparam int IRQ_TRIG = 0;
   localparam int IRQ_FULL = 1;
   localparam int IRQ_W    = 2;

   // response codes
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // count modes
   typedef enum logic [1:0] {
      COUNT_TIME  = 2'b00,
      COUNT_STATE = 2'b01,
      COUNT_OFF   = 2'b10
   } count_mode_t;

   // entry tag
   typedef enum logic [1:0] {
      TAG_STORE   = 2'b00,
      TAG_PRE     = 2'b01,
      TAG_TRIGGER = 2'b10
   } entry_tag_t;

   // capture run state
   typedef enum logic [1:0] {
      RUN_IDLE    = 2'b00,
      RUN_ACTIVE  = 2'b01,
      RUN_DONE    = 2'b10
   } run_state_t;

   // one captured bus state with its qualifier match flags
   typedef struct packed {
      logic [STATE_W-1:0] data;
      logic               trig_hit;
      logic               store_hit;
      logic               pre_hit;
      logic               count_hit;
   } capture_t;

   // one trace memory entry
   typedef struct packed {
      entry_tag_t         tag;
      logic [COUNT_W-1:0] count;
      logic [STATE_W-1:0] data;
   } entry_t;

endpackage : trace_store_pkg

// [verilog/bus_trace_store_qualifier.sv]
// How it works
// - trigger state is written to memory unless memory is full
// - keep two pre-store states before each store
// - pre-store off after reset, host enables it
// - state matching pre and store is stored
// - time counting default, depth 512 states
// - state count on each captured counted state, depth 512
// - counting off drops count, depth 1024
// - run-until-halt never triggers, stops on halt
// - background monitor break stops capturing states
// - foreground monitor break keeps capturing unless halted
`timescale 1ns/10ps
`default_nettype none

module bus_trace_store_qualifier
   import trace_store_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic          cap_valid,
   input  wire capture_t      cap_in,
   input  wire logic          in_monitor,
   input  wire logic          monitor_is_bg,
   input  wire logic          cpu_halted,
   input  wire logic [7:0]    s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   output logic [1:0]         s_axi_bresp,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   input  wire logic [7:0]    s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready,
   output logic               irq
);

   // registers
   logic [31:0]        ctrl_q;       // control word
   logic [IRQ_W-1:0]   irq_q;        // sticky events
   logic [IRQ_W-1:0]   mask_q;       // event mask
   logic [ADDR_W-1:0]  rd_addr_q;    // memory read pointer
   run_state_t         run_q;        // capture run state
   logic               triggered_q;  // trigger seen
   logic [10:0]        fill_q;       // entries written
   logic [COUNT_W-1:0] count_q;      // running count since last entry
   capture_t           pre_q [PRE_SLOTS]; // pre-store slots, oldest first
   logic [PRE_CNT_W-1:0] pre_n_q;    // filled slots
   logic [PRE_CNT_W-1:0] drain_q;    // slots still to write
   capture_t           held_q;       // store state held behind pre-stores
   logic [COUNT_W-1:0] held_cnt_q;   // count belonging to held state
   logic               held_trig_q;  // held state is trigger
   entry_t             mem [2**ADDR_W]; // trace memory
   entry_t             rd_ent_q;     // registered read entry

   // host write pulses and the decoded write address
   logic ctrl_start, ctrl_halt, wr_fire;
   logic [7:0] waddr;

   // decoded control
   count_mode_t mode;
   logic        pre_en;
   logic        on_halt;
   logic [10:0] depth;
   assign mode    = count_mode_t'(ctrl_q[CTRL_MODE_LO +: 2]);
   assign pre_en  = ctrl_q[CTRL_PRE_EN];
   assign on_halt = ctrl_q[CTRL_ON_HALT];
   // depth follows count mode
   assign depth   = (mode == COUNT_OFF) ? DEPTH_NO_COUNT : DEPTH_COUNTED;

   // capture gating: a background break freezes capture, foreground keeps it unless cpu_halted
   logic capturing;
   assign capturing = (run_q == RUN_ACTIVE) && cap_valid && !cpu_halted
                      && !(in_monitor && monitor_is_bg);

   // classification of the current state
   logic is_trig, is_store, is_pre, full, draining;
   assign full     = (fill_q >= depth);
   assign draining = (drain_q != '0);
   // on-halt runs suppress triggering; host keeps other trigger options off
   assign is_trig  = capturing && cap_in.trig_hit && !triggered_q && !on_halt;
   assign is_store = capturing && (cap_in.store_hit || is_trig);
   // a state that is also a store state counts as a normal store
   assign is_pre   = capturing && pre_en && cap_in.pre_hit && !is_store;

   // write port selection
   logic       wr_en;
   entry_t     wr_ent;
   logic [COUNT_W-1:0] cnt_now;
   always_comb
   begin
      // count shown with a direct store
      cnt_now = (mode == COUNT_OFF) ? '0 : count_q;
      wr_en   = 1'b0;
      wr_ent  = '{tag: TAG_STORE, count: '0, data: '0};
      if (draining)
      begin
         // pre-store slots go out ahead of the held store
         wr_en  = 1'b1;
         wr_ent = '{tag: TAG_PRE, count: '0, data: pre_q[PRE_SLOTS - 32'(drain_q)].data};
      end
      else if (held_trig_q || held_cnt_q != '0 || held_q.store_hit)
      begin
         // held store after its pre-stores
         wr_en  = 1'b1;
         wr_ent = '{tag: held_trig_q ? TAG_TRIGGER : TAG_STORE,
                    count: held_cnt_q, data: held_q.data};
      end
      else if (is_store && pre_n_q == '0)
      begin
         // store with nothing pending goes straight in
         wr_en  = 1'b1;
         wr_ent = '{tag: is_trig ? TAG_TRIGGER : TAG_STORE, count: cnt_now,
                    data: cap_in.data};
      end
      // full memory drops writes, trigger included
      if (full)
         wr_en = 1'b0;
   end

   // hold a store while its pre-stores drain (no capture during a drain assumed)
   logic start_drain;
   assign start_drain = is_store && pre_n_q != '0 && !draining;

   // pre-store slot fill count and drain counter
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pre_n_q <= '0;
         drain_q <= '0;
      end
      else if (start_drain)
      begin
         // drain the collected slots
         drain_q <= pre_n_q;
         pre_n_q <= '0;
      end
      else if (draining)
         drain_q <= drain_q - 2'h1;
      else if (is_pre)
      begin
         // keep only the two most recent
         pre_n_q <= (pre_n_q == 2'h2) ? 2'h2 : pre_n_q + 2'h1;
      end
      else if (is_store || !pre_en)
         pre_n_q <= '0;
   end

   // slot data, one generate entry per slot
   genvar gi;
   generate
      for (gi = 0; gi < PRE_SLOTS; gi++)
      begin : g_slot
         always_ff @(posedge clk or posedge rst)
         begin
            if (rst)
               pre_q[gi] <= '0;
            else if (is_pre && !draining && !start_drain)
            begin
               // shift toward slot 0, newest in last slot
               pre_q[gi] <= (gi == PRE_SLOTS-1) ? cap_in : pre_q[(gi+1) % PRE_SLOTS];
            end
         end
      end
   endgenerate

   // held store state
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         held_q      <= '0;
         held_cnt_q  <= '0;
         held_trig_q <= 1'b0;
      end
      else if (start_drain)
      begin
         held_q      <= cap_in;
         held_q.store_hit <= 1'b1;
         held_cnt_q  <= cnt_now;
         held_trig_q <= is_trig;
      end
      else if (!draining)
      begin
         // released once written
         held_q      <= '0;
         held_cnt_q  <= '0;
         held_trig_q <= 1'b0;
      end
   end

   // count: time ticks every cycle, state counts every captured counted state
   logic count_tick, entry_taken;
   assign count_tick  = (mode == COUNT_TIME && run_q == RUN_ACTIVE)
                        || (mode == COUNT_STATE && capturing && cap_in.count_hit);
   assign entry_taken = is_store;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         count_q <= '0;
      else if (run_q != RUN_ACTIVE || ctrl_start)
         count_q <= '0; // a new trace never inherits the old run's count
      else if (entry_taken)
      begin
         // relative count restarts at each stored state
         count_q <= count_tick ? {{(COUNT_W-1){1'b0}}, 1'b1} : '0;
      end
      else if (count_tick)
         count_q <= count_q + {{(COUNT_W-1){1'b0}}, 1'b1};
   end

   // trace memory write; unmatched states write nothing
   always_ff @(posedge clk)
   begin
      if (wr_en)
      begin
         mem[fill_q[ADDR_W-1:0]] <= wr_ent;
      end
   end

   // fill pointer, run state, trigger flag
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         fill_q      <= '0;
         run_q       <= RUN_IDLE;
         triggered_q <= 1'b0;
      end
      else if (ctrl_start)
      begin
         // new trace
         fill_q      <= '0;
         run_q       <= RUN_ACTIVE;
         triggered_q <= 1'b0;
      end
      else
      begin
         if (wr_en)
            fill_q <= fill_q + 11'h1;
         if (is_trig)
            triggered_q <= 1'b1;
         // halt command ends capture in every mode
         if (ctrl_halt || (wr_en && fill_q + 11'h1 >= depth))
            run_q <= RUN_DONE;
      end
   end

   // axi4-lite write channel: accept address and data together
   assign waddr         = s_axi_awaddr;
   assign wr_fire       = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign s_axi_awready = wr_fire;
   assign s_axi_wready  = wr_fire;
   assign ctrl_start    = wr_fire && waddr == CTRL_OFS && s_axi_wstrb[0]
                          && s_axi_wdata[CTRL_START];
   assign ctrl_halt     = wr_fire && waddr == CTRL_OFS && s_axi_wstrb[0]
                          && s_axi_wdata[CTRL_HALT];

   // write response and registers
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ctrl_q       <= CTRL_RESET;
         mask_q       <= '0;
         rd_addr_q    <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= RESP_OKAY;
         case (waddr)
            CTRL_OFS:
            begin
               // start and halt bits act as pulses
               if (s_axi_wstrb[0])
               begin
                  ctrl_q[7:0] <= s_axi_wdata[7:0] & 8'hFC;
               end
            end
            MASK_OFS:  mask_q    <= s_axi_wdata[IRQ_W-1:0];
            RADDR_OFS: rd_addr_q <= s_axi_wdata[ADDR_W-1:0];
            IRQ_OFS:   ;
            default:   s_axi_bresp <= RESP_SLVERR;
         endcase
      end
      else if (s_axi_bready)
      begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // sticky events, set wins over write-one-to-clear
   logic [IRQ_W-1:0] irq_set, irq_clr;
   assign irq_set[IRQ_TRIG] = is_trig;
   assign irq_set[IRQ_FULL] = wr_en && (fill_q + 11'h1 >= depth);
   assign irq_clr = (wr_fire && waddr == IRQ_OFS) ? s_axi_wdata[IRQ_W-1:0] : '0;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         irq_q <= '0;
      else
         irq_q <= (irq_q & ~irq_clr) | irq_set;
   end
   assign irq = |(irq_q & mask_q);

   // registered memory read port
   always_ff @(posedge clk)
   begin
      rd_ent_q <= mem[rd_addr_q];
   end

   // axi4-lite read channel
   logic [31:0] rmux;
   always_comb
   begin
      rmux = '0;
      case (s_axi_araddr)
         CTRL_OFS:   rmux = ctrl_q;
         STATUS_OFS: rmux = {28'h0, full, triggered_q, run_q};
         IRQ_OFS:    rmux = {30'h0, irq_q};
         MASK_OFS:   rmux = {30'h0, mask_q};
         FILL_OFS:   rmux = {21'h0, fill_q};
         RADDR_OFS:  rmux = {22'h0, rd_addr_q};
         RSTAT_LO:   rmux = rd_ent_q.data[31:0];
         RSTAT_HI:   rmux = rd_ent_q.data[63:32];
         RCOUNT_OFS: rmux = rd_ent_q.count;
         RTAG_OFS:   rmux = {30'h0, rd_ent_q.tag};
         default:    rmux = '0;
      endcase
   end

   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= RESP_OKAY;
      end
      else if (s_axi_arvalid && !s_axi_rvalid)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rmux;
         s_axi_rresp  <= (s_axi_araddr > RTAG_OFS || s_axi_araddr[1:0] != 2'h0)
                         ? RESP_SLVERR : RESP_OKAY;
      end
      else if (s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule : bus_trace_store_qualifier

`default_nettype wire

// [test/trace_store_props.sv]
`timescale 1ns/10ps
`default_nettype none

// handshake and interrupt timing seen at the block's ports
module trace_store_props
(
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        cap_valid,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        irq
);
   // one clock domain, one reset
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // a full write with no answer pending is taken and answered next cycle
   property p_wr_taken;
      s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
         |-> s_axi_awready && s_axi_wready ##1 s_axi_bvalid;
   endproperty
   a_wr_taken: assert property (p_wr_taken) else $error("write not taken or not answered");
   // an address without its data is refused
   property p_aw_alone;
      s_axi_awvalid && !s_axi_wvalid |-> !s_axi_awready;
   endproperty
   a_aw_alone: assert property (p_aw_alone) else $error("lone write address taken");
   // the write answer stands until accepted
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
   // the write answer leaves once accepted
   property p_b_drop;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   a_b_drop: assert property (p_b_drop) else $error("write answer repeated");
   // a read with no answer pending is taken and answered next cycle
   property p_rd_taken;
      s_axi_arvalid && !s_axi_rvalid |-> s_axi_arready ##1 s_axi_rvalid;
   endproperty
   a_rd_taken: assert property (p_rd_taken) else $error("read not taken or not answered");
   // read data stands until accepted
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready
         |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read answer changed early");
   // the read answer leaves once accepted
   property p_r_drop;
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
   endproperty
   a_r_drop: assert property (p_r_drop) else $error("read answer repeated");
   // the interrupt moves only after a capture (or its two-slot drain) or a write
   property p_irq_cause;
      $changed(irq) |-> $past(s_axi_awvalid && s_axi_wvalid) || $past(cap_valid)
         || $past(cap_valid, 2) || $past(cap_valid, 3) || $past(cap_valid, 4);
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("interrupt moved without cause");
endmodule : trace_store_props

bind bus_trace_store_qualifier trace_store_props u_props
(
   .clk, .rst, .cap_valid, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq
);

`default_nettype wire

// [test/bus_source_model.sv]
`timescale 1ns/10ps
`default_nettype none

// stands in for the emulated processor bus and its monitor state
module bus_source_model
   import trace_store_pkg::*;
(
   input  wire logic clk,
   output logic      cap_valid,
   output capture_t  cap_in,
   output logic      in_monitor,
   output logic      monitor_is_bg,
   output logic      cpu_halted
);
   // bus idle, processor running user code at time zero
   initial
   begin
      cap_valid     = 1'b0;
      cap_in        = '0;
      in_monitor    = 1'b0;
      monitor_is_bg = 1'b0;
      cpu_halted    = 1'b0;
   end

   // one captured state for one cycle; hits are trigger, store, pre, count
   task automatic offer(input logic [3:0] h, input logic [63:0] d);
      @(posedge clk);
      cap_valid <= 1'b1;
      cap_in    <= {d, h};
      @(posedge clk);
      cap_valid <= 1'b0;
      // lines do not keep the old state once the cycle has passed
      cap_in    <= ~{d, h};
   endtask : offer

   // monitor state: in monitor, background monitor, halted
   task automatic gate(input logic [2:0] g);
      @(posedge clk);
      {in_monitor, monitor_is_bg, cpu_halted} <= g;
   endtask : gate
endmodule : bus_source_model

`default_nettype wire

// [test/bus_trace_store_qualifier_bench.sv]
`timescale 1ns/10ps
`default_nettype none

// register-level tests of the trace store qualifier
module bus_trace_store_qualifier_bench
   import trace_store_pkg::*;
;
   logic        clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata;
   logic [3:0]  s_axi_wstrb;
   wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   wire logic [1:0]  s_axi_bresp, s_axi_rresp;
   wire logic [31:0] s_axi_rdata;
   wire logic   cap_valid, in_monitor, monitor_is_bg, cpu_halted;
   wire capture_t    cap_in;
   int          num_errors, checks;
   logic [31:0] rd_q;   // last read data
   logic [1:0]  rs_q;   // last response code
   // expected trace after the pre-store test
   entry_tag_t  tag_q [5] = '{TAG_PRE, TAG_PRE, TAG_STORE, TAG_STORE, TAG_TRIGGER};
   logic [31:0] dat_q [5] = '{32'h0B, 32'h0C, 32'h0D, 32'h0F, 32'h10};
   // monitor states and the fill expected after each
   logic [2:0]  gate_q [3] = '{3'h6, 3'h4, 3'h5};
   logic [31:0] fill_q [3] = '{32'h1, 32'h2, 32'h2};

   bus_trace_store_qualifier dut
   (
      .clk, .rst, .cap_valid, .cap_in, .in_monitor, .monitor_is_bg, .cpu_halted,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .irq
   );
   bus_source_model src
   (
      .clk, .cap_valid, .cap_in, .in_monitor, .monitor_is_bg, .cpu_halted
   );

   // 200 MHz clock
   always #2.5 clk = ~clk;

   // one register write, address and data offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do @(posedge clk); while (!(s_axi_awready && s_axi_wready));
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid  <= 1'b0;
      do @(posedge clk); while (!s_axi_bvalid);
      s_axi_bready  <= 1'b0;
      rs_q = s_axi_bresp;
   endtask : wr

   // one register read
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk); while (!s_axi_rvalid);
      s_axi_rready  <= 1'b0;
      rd_q = s_axi_rdata;
      rs_q = s_axi_rresp;
   endtask : rd

   // compare and count
   task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("wrong value %s expected %0h seen %0h", n, exp, seen);
      end
   endtask : check

   // read a register and compare it
   task automatic expect_reg(input string n, input logic [7:0] a, input logic [31:0] e);
      rd(a);
      check(n, rd_q, e);
   endtask : expect_reg

   // select a trace entry and compare its tag and low data word
   task automatic entry(input logic [9:0] i, input entry_tag_t t, input logic [31:0] d);
      wr(RADDR_OFS, {22'h0, i});
      repeat (2) @(posedge clk);
      expect_reg("tag", RTAG_OFS, {30'h0, t});
      expect_reg("data", RSTAT_LO, d);
   endtask : entry

   // end of test line
   task automatic done(input string n);
      $display("test %s finished", n);
   endtask : done

   // counts, verdict, end of run
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : finish_test

   // cuts a hang short
   initial
   begin
      repeat (30000) @(posedge clk);
      num_errors++;
      finish_test();
   end

   // test sequence
   initial
   begin
      clk = 1'b0;
      rst = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata  = 32'h0;
      s_axi_wstrb  = 4'hF;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      // reset values and an unmapped place
      expect_reg("ctrl", CTRL_OFS, CTRL_RESET);
      check("ctrl resp", {30'h0, rs_q}, {30'h0, RESP_OKAY});
      rd(8'h40);
      check("unmapped", {30'h0, rs_q}, {30'h0, RESP_SLVERR});
      check("unmapped data", rd_q, 32'h0);
      wr(8'h40, 32'h0);
      check("unmapped write", {30'h0, rs_q}, {30'h0, RESP_SLVERR});
      done("reset");
      // pre-stores ahead of a store, a discarded state, a double match, a trigger
      wr(MASK_OFS, 32'h1);
      check("mask resp", {30'h0, rs_q}, {30'h0, RESP_OKAY});
      wr(CTRL_OFS, 32'h5);
      src.offer(4'h2, 64'h0A);
      src.offer(4'h2, 64'h0B);
      src.offer(4'h2, 64'h0C);
      src.offer(4'h4, 64'h0D);
      repeat (2) @(posedge clk);
      src.offer(4'h0, 64'h0E);
      src.offer(4'h6, 64'h0F);
      repeat (2) @(posedge clk);
      src.offer(4'h8, 64'h10);
      repeat (4) @(posedge clk);
      expect_reg("fill", FILL_OFS, 32'h5);
      for (int i = 0; i < 5; i++)
         entry(10'(i), tag_q[i], dat_q[i]);
      // the trigger came four cycles after the previous stored state
      expect_reg("count", RCOUNT_OFS, 32'h4);
      check("irq", {31'h0, irq}, 32'h1);
      wr(IRQ_OFS, 32'h1);
      check("irq", {31'h0, irq}, 32'h0);
      done("prestore");
      // state counting without pre-store enable
      wr(CTRL_OFS, 32'h9);
      repeat (3) src.offer(4'h3, 64'h1);
      src.offer(4'h4, 64'h0000_0077_0000_0055);
      repeat (4) @(posedge clk);
      expect_reg("fill", FILL_OFS, 32'h1);
      entry(10'h0, TAG_STORE, 32'h55);
      expect_reg("data hi", RSTAT_HI, 32'h77);
      expect_reg("count", RCOUNT_OFS, 32'h3);
      done("state count");
      // fill until refused, with a count field and without
      for (int m = 0; m < 2; m++)
      begin
         wr(MASK_OFS, 32'h0);
         wr(CTRL_OFS, (m == 1) ? 32'h11 : 32'h1);
         for (int i = 0; i < 1030; i++)
            src.offer(4'h4, 64'(i));
         repeat (4) @(posedge clk);
         expect_reg("fill", FILL_OFS, (m == 1) ? 32'h400 : 32'h200);
         expect_reg("status", STATUS_OFS, 32'hA);
         check("irq", {31'h0, irq}, 32'h0);
         wr(MASK_OFS, 32'h2);
         check("irq", {31'h0, irq}, 32'h1);
         wr(IRQ_OFS, 32'h2);
         check("irq", {31'h0, irq}, 32'h0);
      end
      entry(10'h3FF, TAG_STORE, 32'h3FF);
      expect_reg("count", RCOUNT_OFS, 32'h0);
      done("depth");
      // run until halt, with monitor breaks; on-halt is set alone
      wr(CTRL_OFS, 32'h21);
      src.offer(4'hC, 64'h1);
      repeat (4) @(posedge clk);
      expect_reg("status", STATUS_OFS, 32'h1);
      for (int k = 0; k < 3; k++)
      begin
         src.gate(gate_q[k]);
         src.offer(4'h4, 64'h2);
         repeat (4) @(posedge clk);
         expect_reg("fill", FILL_OFS, fill_q[k]);
      end
      src.gate(3'h0);
      wr(CTRL_OFS, 32'h2);
      expect_reg("status", STATUS_OFS, 32'h2);
      done("on halt");
      finish_test();
   end
endmodule : bus_trace_store_qualifier_bench

`default_nettype wire
